/* bench/taal_host.sv */
// Behavioural alert-servicing host on the far side of the alert line.
// Assumes the wired alert line level and the serial engine's byte port.
`timescale 1ns/1ps
module taal_host (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Alert line and response byte
   input  wire logic       alert_line,
   input  wire logic [7:0] ara_byte,
   // Bench commands: service enable, lose arbitration
   input  wire logic       en,
   input  wire logic       lose,
   // Response read strobes and captured byte
   output logic            ara_req,
   output logic            ara_done,
   output logic [7:0]      got
);
   // Poll the line; a slow host just leaves en low for a while
   initial begin
      ara_req = 1'b0;
      ara_done = 1'b0;
      got = 8'h00;
      forever begin
         @(posedge mclk);
         if (resetn && en && alert_line === 1'b0) begin
            ara_req <= 1'b1;
            @(posedge mclk);
            ara_req <= 1'b0;
            @(posedge mclk);
            got = ara_byte;
            // Losing arbitration means no completion strobe
            if (!lose && got[0] === 1'b1)
               ara_done <= 1'b1;
            @(posedge mclk);
            ara_done <= 1'b0;
            repeat (4) @(posedge mclk);
         end
      end
   end
endmodule

/* bench/taal_top_tb.sv */
// Self-checking bench of the thermal alarm block against a scalar model.
// Assumes the host model answers alerts only while en is high.
`timescale 1ns/1ps
`define CHK(n,e,s) begin checks_done++; if ((s) !== (e)) begin \
 miscompares++; $display("ERROR %s exp %h got %h", n, e, s); end end
module taal_top_tb;
   import taal_pkg::*;
   localparam logic [6:0] SA  = 7'h2a; // Arbitrary test address
   localparam logic [7:0] ARB = {SA, 1'b1};
   logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, adc_temp = 8'h00, ara_byte, fan_duty, got;
   logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'h207a;
   logic        pready, pslverr, err, conv_start = 0, conv_done = 0;
   logic        flt = 0, gp1 = 0, gp2 = 0, en = 0, lose = 0;
   logic        ara_req, ara_done, ara_pending, alert_o, alert_oe_n;
   logic        thermostat_out, fan_forced;
   integer      miscompares = 0, checks_done = 0, cyc = 0, i;
   integer      hi = 127, lo = -55, crit = 100, temp = 0, duty = 0;
   bit          pend = 0, therm = 0, hi_arm = 1, lo_arm = 1, pol = 0;
   bit          fanon = 0, mask = 0;
   // Pull-up holds the shared line high when released
   wire         alert_line = alert_oe_n ? 1'b1 : alert_o;

   taal_top #(.SLAVE_ADDR(SA)) i_taal_top (.mclk(mclk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .conv_start(conv_start), .conv_done(conv_done),
      .adc_temp(adc_temp), .diode_fault_raw(flt), .gp_pin_one(gp1),
      .gp_pin_two(gp2), .ara_req(ara_req), .ara_done(ara_done),
      .ara_byte(ara_byte), .ara_pending(ara_pending), .alert_o(alert_o),
      .alert_oe_n(alert_oe_n), .thermostat_out(thermostat_out),
      .fan_duty(fan_duty), .fan_forced(fan_forced));
   taal_host i_taal_host (.mclk(mclk), .resetn(resetn),
      .alert_line(alert_line), .ara_byte(ara_byte), .en(en), .lose(lose),
      .ara_req(ara_req), .ara_done(ara_done), .got(got));

   // Clock and hang guard
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task results;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // APB cycle; answer taken at the rising edge that sees pready high
   task apb(input bit w, input logic [5:0] idx, input logic [7:0] d);
      @(posedge mclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdat = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task rd(input logic [5:0] idx, input logic [7:0] m, e, input string n);
      apb(0, idx, 8'h00);
      `CHK(n, e, rdat[7:0] & m)
      `CHK("slverr", 1'b0, err)
   endtask

   // Model of both latches; each threshold fires once until rewritten
   task eval;
      if (temp >= crit) therm = 1;
      else if (temp <= crit - 5) therm = 0;
      if (hi_arm && temp >= hi) begin
         pend = 1;
         hi_arm = 0;
      end
      if (lo_arm && temp <= lo) begin
         pend = 1;
         lo_arm = 0;
      end
   endtask

   task chk_out;
      `CHK("therm", pol ? therm : !therm, thermostat_out)
      `CHK("pend", pend, ara_pending)
      `CHK("oe_n", !(pend && !mask), alert_oe_n)
      `CHK("drv", 1'b0, alert_o)
      `CHK("fan", (fanon && therm) ? 8'hff : duty[7:0], fan_duty)
      `CHK("force", fanon && therm, fan_forced)
   endtask

   task conv(input integer t);
      @(posedge mclk);
      conv_start <= 1;
      @(posedge mclk);
      conv_start <= 0;
      conv_done <= 1;
      adc_temp <= t[7:0];
      @(posedge mclk);
      conv_done <= 0;
      temp = flt ? 127 : t;
      if (flt) pend = 1;
      eval;
      repeat (3) @(posedge mclk);
      chk_out;
      rd(IDX_TEMP, 8'hff, temp[7:0], "temp");
   endtask

   task wr_lim(input logic [5:0] idx, input integer v);
      apb(1, idx, v[7:0]);
      if (idx == IDX_HI_WR) begin
         hi = v;
         hi_arm = 1;
      end
      else crit = v;
      eval;
      repeat (3) @(posedge mclk);
      chk_out;
   endtask

   task serve;
      en <= 1;
      i = 0;
      @(negedge mclk);
      while (ara_pending !== 1'b0 && i < 60) begin
         @(negedge mclk);
         i++;
      end
      @(posedge mclk);
      en <= 0;
      pend = 0;
      `CHK("ara", ARB, got)
      repeat (2) @(posedge mclk);
      chk_out;
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1;
      @(posedge mclk);
      chk_out;
      rd(IDX_CMD, 8'hff, CMD_RST, "cmd");
      rd(IDX_STAT, 8'hff, 8'h00, "stat");
      apb(1, IDX_CFG_WR, 8'h06);
      fanon = 1;
      apb(1, IDX_DUTY_WR, 8'h40);
      duty = 64;
      $display("test reset done");
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         conv(integer'(seed % 130) - 40);
      end
      wr_lim(IDX_HI_WR, 80);
      conv(100);
      rd(IDX_DUTY_RD, 8'hff, 8'h40, "duty");
      conv(96);
      conv(95);
      serve;
      conv(100);
      wr_lim(IDX_CRIT_WR, 120);
      wr_lim(IDX_HI_WR, 80);
      apb(1, IDX_CFG_WR, 8'h26);
      pol = 1;
      wr_lim(IDX_CRIT_WR, 100);
      serve;
      $display("test thresholds done");
      gp1 <= 1;
      repeat (6) @(posedge mclk);
      pend = 1;
      chk_out;
      lose <= 1;
      en <= 1;
      repeat (30) @(posedge mclk);
      en <= 0;
      chk_out;
      lose <= 0;
      serve;
      flt <= 1;
      repeat (4) @(posedge mclk);
      rd(IDX_STAT, 8'h04, 8'h00, "flt0");
      conv(30);
      rd(IDX_STAT, 8'h04, 8'h04, "flt1");
      flt <= 0;
      serve;
      conv(-60);
      // Mask gates the pin only; the latch keeps pending
      apb(1, IDX_CFG_WR, 8'ha6);
      mask = 1;
      gp1 <= 0;
      repeat (6) @(posedge mclk);
      pend = 1;
      chk_out;
      apb(0, 6'h00, 8'h00);
      `CHK("err", 1'b1, err)
      $display("test alerts done");
      results();
   end
endmodule

/* hdl/taal_pkg.sv */
// Constants, field positions and enumerations of the thermal alarm block.
// Assumes an APB master on mclk and an ADC front end on the same clock.
// Function
// - Thermostat latch sets when latest result reaches or passes critical.
// - Thermostat output active low; a configuration bit makes it high.
// - Thermostat latch releases only at or below critical minus five.
// - Comparisons run after each conversion and after each limit write.
// - Limit writes in standby re-evaluate using the last result.
// - Critical comparison never raises the bus alert.
// - Fan-on bit 2 with thermostat latch active forces full fan drive.
// - Forcing keeps stored duty; programmed duty returns on release.
// - Diode fault detector sampled into status at each conversion start.
// - Status shows no diode fault until the first conversion starts.
// - Diode fault reports plus 127 degrees and sets the alert latch.
// - Alert output comes from a latch cleared only by alert response.
// - Alert set by high, low, diode fault or either pin edge.
// - Pending alert never stops conversions; results stay readable.
// - Alert output is open drain, pulling low only.
// - A threshold that alerted stays silent until rewritten.
// - Other new alarm conditions still raise alerts meanwhile.
// - Host reads alert response address; pending devices send address.
// - Lower address wins; loser does not acknowledge, keeps alert low.
// - Latch cleared only after address successfully delivered.
// - Eight-bit command index register resets to one.
// - Results and limits are 8-bit two's complement, one degree per bit.
// - Alert when result reaches high limit or reaches low limit.
// - Response byte holds seven-bit address above a logic one.
package taal_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_TEMP     = 6'h01;
   localparam logic [5:0] IDX_STAT     = 6'h02;
   localparam logic [5:0] IDX_CFG_RD   = 6'h03;
   localparam logic [5:0] IDX_HI_RD    = 6'h07;
   localparam logic [5:0] IDX_LO_RD    = 6'h08;
   localparam logic [5:0] IDX_CFG_WR   = 6'h09;
   localparam logic [5:0] IDX_HI_WR    = 6'h0d;
   localparam logic [5:0] IDX_LO_WR    = 6'h0e;
   localparam logic [5:0] IDX_CRIT_RD  = 6'h10;
   localparam logic [5:0] IDX_DUTY_RD  = 6'h13;
   localparam logic [5:0] IDX_CRIT_WR  = 6'h18;
   localparam logic [5:0] IDX_DUTY_WR  = 6'h1b;
   localparam logic [5:0] IDX_CMD      = 6'h1d;
   // Values after reset, then fixed constants
   localparam logic [7:0] CFG_RST      = 8'h02;
   localparam logic [7:0] HI_RST       = 8'h7f;
   localparam logic [7:0] LO_RST       = 8'hc9;
   localparam logic [7:0] CRIT_RST     = 8'h64;
   localparam logic [7:0] CMD_RST      = 8'h01;
   localparam logic [7:0] DUTY_RST     = 8'h00;
   localparam logic [7:0] FAULT_TEMP   = 8'h7f;
   localparam logic [7:0] FULL_DRIVE   = 8'hff;
   localparam logic [8:0] HYST_DEG     = 9'h005;
   localparam logic [6:0] ARA_ADDR     = 7'h0c;
   // Configuration and status bit positions
   localparam int CFG_FANON_BIT = 2;
   localparam int CFG_POL_BIT   = 5;
   localparam int CFG_MASK_BIT  = 7;
   localparam int ST_FAULT_BIT  = 2;
   localparam int ST_LO_BIT     = 3;
   localparam int ST_HI_BIT     = 4;
   localparam int ST_CRIT_BIT   = 5;
   // Bus slave phase
   typedef enum logic [0:0] {
      TAAL_IDLE = 1'b0,
      TAAL_RESP = 1'b1
   } taal_phase_t;
endpackage

/* hdl/taal_top.sv */
// Alarm, thermostat and alert logic of a remote-diode temperature monitor.
// Assumes conversion strobes and results on mclk; pins and fault raw.
`timescale 1ns/1ps
module taal_top
   import taal_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h4c  // Arbitrary default address
)(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // ADC front end, same clock
   input  wire logic        conv_start,
   input  wire logic        conv_done,
   input  wire logic [7:0]  adc_temp,
   // Asynchronous sense inputs
   input  wire logic        diode_fault_raw,
   input  wire logic        gp_pin_one,
   input  wire logic        gp_pin_two,
   // Alert response from the serial engine
   input  wire logic        ara_req,
   input  wire logic        ara_done,
   output logic [7:0]       ara_byte,
   output logic             ara_pending,
   // Open-drain alert pin; thermostat pin driven both high and low
   output logic             alert_o,
   output logic             alert_oe_n,
   output logic             thermostat_out,
   // Fan drive
   output logic [7:0]       fan_duty,
   output logic             fan_forced
);

   // Bus state
   taal_phase_t phase_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   // Register file
   logic [7:0]  cfg_q;
   logic [7:0]  hi_q;
   logic [7:0]  lo_q;
   logic [7:0]  crit_q;
   logic [7:0]  duty_q;
   logic [7:0]  cmd_q;
   logic [7:0]  temp_q;
   // Alarm state
   logic        fault_q;
   logic        eval_q;
   logic        hi_arm_q;
   logic        lo_arm_q;
   logic        hi_flag_q;
   logic        lo_flag_q;
   logic        therm_q;
   logic        therm_d;
   logic        alert_q;
   logic        alert_d;
   // Synchronisers, stage two feeds logic, stage three for edges
   logic [2:0]  gp1_s;
   logic [2:0]  gp2_s;
   logic [1:0]  flt_s;
   // Output flops
   logic        oe_n_q;
   logic        tout_q;
   logic [7:0]  fan_q;
   logic        force_q;
   logic [7:0]  ara_q;

   // Bus decode
   wire         acc      = psel & penable;
   wire         fire     = acc & (phase_q == TAAL_RESP);
   wire         wr_fire  = fire & pwrite & ~pslverr_q;
   wire [5:0]   idx      = paddr[7:2];
   wire [7:0]   wbyte    = pwdata[7:0];
   wire         wr_cfg   = wr_fire & (idx == IDX_CFG_WR);
   wire         wr_hi    = wr_fire & (idx == IDX_HI_WR);
   wire         wr_lo    = wr_fire & (idx == IDX_LO_WR);
   wire         wr_crit  = wr_fire & (idx == IDX_CRIT_WR);
   wire         wr_duty  = wr_fire & (idx == IDX_DUTY_WR);
   wire         wr_cmd   = wr_fire & (idx == IDX_CMD);
   wire         lim_wr   = wr_hi | wr_lo | wr_crit;

   // Status byte readout
   wire [7:0]   status = {2'b00, therm_q, hi_flag_q, lo_flag_q,
                          fault_q, gp2_s[1], gp1_s[1]};

   // Read mux; a write-only index or bad alignment is an error
   logic [7:0]  rsel;
   logic        rok;
   logic        wok;
   always_comb begin
      rsel = 8'h00;
      rok  = 1'b1;
      case (idx)
         IDX_TEMP:    rsel = temp_q;
         IDX_STAT:    rsel = status;
         IDX_CFG_RD:  rsel = cfg_q;
         IDX_HI_RD:   rsel = hi_q;
         IDX_LO_RD:   rsel = lo_q;
         IDX_CRIT_RD: rsel = crit_q;
         IDX_DUTY_RD: rsel = duty_q;
         IDX_CMD:     rsel = cmd_q;
         default:     rok  = 1'b0;
      endcase
   end
   assign wok = (idx == IDX_CFG_WR) | (idx == IDX_HI_WR) |
                (idx == IDX_LO_WR) | (idx == IDX_CRIT_WR) |
                (idx == IDX_DUTY_WR) | (idx == IDX_CMD);
   wire bad = (paddr[1:0] != 2'b00) | (pwrite ? ~wok : ~rok);

   // One wait state: answer computed in first access cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         phase_q   <= TAAL_IDLE;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (acc && phase_q == TAAL_IDLE) begin
         phase_q   <= TAAL_RESP;
         prdata_q  <= (pwrite | bad) ? 32'h0000_0000 : {24'h000000, rsel};
         pslverr_q <= bad;
      end else begin
         phase_q   <= TAAL_IDLE;
         pslverr_q <= 1'b0;
      end
   end

   // Software registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cfg_q  <= CFG_RST;
         hi_q   <= HI_RST;
         lo_q   <= LO_RST;
         crit_q <= CRIT_RST;
         duty_q <= DUTY_RST;
         cmd_q  <= CMD_RST;
      end else begin
         if (wr_cfg)  cfg_q  <= wbyte;
         if (wr_hi)   hi_q   <= wbyte;
         if (wr_lo)   lo_q   <= wbyte;
         if (wr_crit) crit_q <= wbyte;
         if (wr_duty) duty_q <= wbyte;
         if (wr_cmd)  cmd_q  <= wbyte;
      end
   end

   // Two flops before any logic reads a pin
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         gp1_s <= 3'b000;
         gp2_s <= 3'b000;
         flt_s <= 2'b00;
      end else begin
         gp1_s <= {gp1_s[1:0], gp_pin_one};
         gp2_s <= {gp2_s[1:0], gp_pin_two};
         flt_s <= {flt_s[0], diode_fault_raw};
      end
   end

   // Fault flag held clear until a conversion samples it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fault_q <= 1'b0;
      end else if (conv_start) begin
         fault_q <= flt_s[1];
      end
   end

   // Results update regardless of a pending alert
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         temp_q <= 8'h00;
      end else if (conv_done) begin
         temp_q <= fault_q ? FAULT_TEMP : adc_temp;
      end
   end

   // Evaluate one cycle later so a fresh limit or result is in place
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         eval_q <= 1'b0;
      end else begin
         eval_q <= conv_done | lim_wr;
      end
   end

   // Signed compares, one degree per bit
   wire signed [8:0] t_s    = {temp_q[7], temp_q};
   wire signed [8:0] crit_s = {crit_q[7], crit_q};
   wire signed [8:0] rel_s  = crit_s - $signed(HYST_DEG);
   wire hi_hit   = $signed(temp_q) >= $signed(hi_q);
   wire lo_hit   = $signed(temp_q) <= $signed(lo_q);
   wire crit_hit = t_s >= crit_s;
   wire crit_rel = t_s <= rel_s;

   // Alarm events
   wire hi_ev    = eval_q & hi_hit & hi_arm_q;
   wire lo_ev    = eval_q & lo_hit & lo_arm_q;
   wire fault_ev = conv_start & flt_s[1];
   wire gp_ev    = (gp1_s[2] ^ gp1_s[1]) | (gp2_s[2] ^ gp2_s[1]);
   // Critical compare is left out on purpose
   wire set_any  = hi_ev | lo_ev | fault_ev | gp_ev;

   // Thresholds rearm only when rewritten; set wins over rearm
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hi_arm_q <= 1'b1;
         lo_arm_q <= 1'b1;
      end else begin
         if (hi_ev)      hi_arm_q <= 1'b0;
         else if (wr_hi) hi_arm_q <= 1'b1;
         if (lo_ev)      lo_arm_q <= 1'b0;
         else if (wr_lo) lo_arm_q <= 1'b1;
      end
   end

   // Status flags follow the latest evaluation
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hi_flag_q <= 1'b0;
         lo_flag_q <= 1'b0;
      end else if (eval_q) begin
         hi_flag_q <= hi_hit;
         lo_flag_q <= lo_hit;
      end
   end

   // Thermostat latch with hysteresis band
   always_comb begin
      therm_d = therm_q;
      if (eval_q && crit_hit)      therm_d = 1'b1;
      else if (eval_q && crit_rel) therm_d = 1'b0;
   end

   // Alert latch; an event in the clearing cycle is kept
   always_comb begin
      alert_d = alert_q;
      if (ara_done) alert_d = 1'b0;
      if (set_any)  alert_d = 1'b1;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         therm_q <= 1'b0;
         alert_q <= 1'b0;
      end else begin
         therm_q <= therm_d;
         alert_q <= alert_d;
      end
   end

   // Pin and fan outputs; loser of arbitration simply keeps pulling low
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         oe_n_q  <= 1'b1;
         tout_q  <= 1'b1;
         fan_q   <= DUTY_RST;
         force_q <= 1'b0;
         ara_q   <= 8'h00;
      end else begin
         oe_n_q  <= ~(alert_d & ~cfg_q[CFG_MASK_BIT]);
         tout_q  <= cfg_q[CFG_POL_BIT] ? therm_d : ~therm_d;
         force_q <= cfg_q[CFG_FANON_BIT] & therm_d;
         fan_q   <= (cfg_q[CFG_FANON_BIT] & therm_d) ? FULL_DRIVE
                                                     : duty_q;
         if (ara_req) ara_q <= {SLAVE_ADDR, 1'b1};
      end
   end

   assign pready         = phase_q == TAAL_RESP;
   assign prdata         = prdata_q;
   assign pslverr        = pslverr_q;
   assign alert_o        = 1'b0;
   assign alert_oe_n     = oe_n_q;
   assign thermostat_out = tout_q;
   assign fan_duty       = fan_q;
   assign fan_forced     = force_q;
   assign ara_byte       = ara_q;
   assign ara_pending    = alert_q;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_ara;
      ara_req ##1 1'b1;
   endsequence

   sequence s_crit_eval;
      eval_q && crit_hit;
   endsequence

   therm_set_a: assert property (s_crit_eval |=> therm_q ##1
      (cfg_q[CFG_POL_BIT] ? tout_q : !tout_q))
      else $error("thermostat not active after critical hit");

   therm_pol_a: assert property ($stable(cfg_q) && $stable(therm_q)
      |-> tout_q == (cfg_q[CFG_POL_BIT] ? therm_q : !therm_q))
      else $error("thermostat polarity wrong");

   therm_hold_a: assert property (therm_q && !(eval_q && crit_rel)
      |=> therm_q)
      else $error("thermostat released inside band");

   eval_wr_a: assert property (lim_wr |=> eval_q)
      else $error("limit write not evaluated");

   no_crit_a: assert property (!alert_q && !set_any && !ara_done
      |=> !alert_q)
      else $error("alert raised without event");

   fan_force_a: assert property (cfg_q[CFG_FANON_BIT] && therm_d
      |=> fan_q == FULL_DRIVE && fan_forced)
      else $error("fan not forced");

   fan_back_a: assert property (!therm_d && $stable(duty_q)
      |=> fan_q == $past(duty_q))
      else $error("fan did not return to duty");

   fault_smp_a: assert property (conv_start
      |=> fault_q == $past(flt_s[1]))
      else $error("fault flag not sampled");

   alert_hold_a: assert property (alert_q && !ara_done |=> alert_q)
      else $error("alert cleared without response");

   alert_set_a: assert property (set_any |=> alert_q ##1
      (cfg_q[CFG_MASK_BIT] || !alert_oe_n))
      else $error("alert event lost");

   od_pin_a: assert property (!alert_oe_n |-> !alert_o)
      else $error("alert drives high");

   rearm_a: assert property (hi_ev ##1 !wr_hi[*2] |=> !hi_ev)
      else $error("threshold alerted twice");

   ara_byte_a: assert property (s_ara |->
      ara_byte == {SLAVE_ADDR, 1'b1})
      else $error("response byte wrong");

   // Fault reading replaces the converter result, whatever the ADC says
   sequence s_fault_conv;
      conv_done && fault_q;
   endsequence

   fault_temp_a: assert property (s_fault_conv
      |=> temp_q == FAULT_TEMP)
      else $error("fault reading not forced");

   temp_upd_a: assert property (conv_done && !fault_q
      |=> temp_q == $past(adc_temp))
      else $error("result not updated");

   therm_rel_a: assert property (therm_q && eval_q && crit_rel
      |=> !therm_q)
      else $error("thermostat not released");

   ara_clear_a: assert property (ara_done && !set_any
      |=> !alert_q && alert_oe_n)
      else $error("alert not cleared by response");

   // A loser gets no done strobe, so the line must stay pulled
   lose_hold_a: assert property (alert_q && !ara_done
      && !cfg_q[CFG_MASK_BIT] |=> !alert_oe_n)
      else $error("alert line released early");

   gp_alert_a: assert property (gp_ev && !hi_arm_q |=> alert_q)
      else $error("pin edge lost while suppressed");

endmodule
